/* rtl/gpb_pkg.sv */
package gpb_pkg;
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned BIDIR_W = 5;
	localparam int unsigned IN_W = 8;
	localparam int unsigned CHSEL_W = 4;
	// register offsets
	localparam logic [15:0] BIDIR_DATA_ADDR = 16'hffdc;
	localparam logic [15:0] INPUT_DATA_ADDR = 16'hffdd;
	localparam logic [15:0] BIDIR_DIR_ADDR = 16'hffec;
	// reset and fixed read values
	localparam logic [7:0] BIDIR_DATA_RST = 8'hc0;
	localparam logic [7:0] BIDIR_DIR_RST = 8'hc0;
	localparam logic [7:0] DIR_READ_VAL = 8'hff;
	localparam logic [7:0] UNMAPPED_VAL = 8'h00;
	localparam logic [1:0] RSVD_HI_VAL = 2'h3;
	localparam logic RSVD_B5_VAL = 1'b0;
	localparam logic [4:0] BIDIR_ZERO = 5'h00;
	localparam logic [7:0] IN_ZERO = 8'h00;
	// channel select: codes below IN_W pick an input port pin
	localparam logic [3:0] CHSEL_IN_LIMIT = 4'h8;

	typedef enum logic [2:0] {
		GPB_MODE_ACTIVE = 3'h0,
		GPB_MODE_SUBACTIVE = 3'h1,
		GPB_MODE_SLEEP = 3'h2,
		GPB_MODE_SUBSLEEP = 3'h3,
		GPB_MODE_WATCH = 3'h4,
		GPB_MODE_STANDBY = 3'h5
	} gpb_mode_e;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} gpb_req_s;

	typedef struct packed {
		logic [4:0] out;
		logic [4:0] oe_n;
	} gpb_pin_s;
endpackage

/* rtl/gpb_ports.sv */
`timescale 1ns/10ps
// How it works
// R01: five-pin port, bits 4..0, each pin input or output; flash variant pin 0 input only.
// R02: data register bits 7 and 6 read 1, writes ignored.
// R03: data register bit 5 reads 0, writes ignored.
// R04: flash variant: data bit 0 reads 0, ignores writes.
// R05: direction bit 1: read returns latched data bit.
// R06: direction bit 0: read returns sampled pin level.
// R07: data register resets to c0, data bits zero.
// R08: direction bit 1 drives data onto pin; 0 makes it input.
// R09: direction register resets to c0, all pins inputs.
// R10: direction register write-only, reads all ones.
// R11: five-pin port released in reset, standby; holds in sleep, watch.
// R12: eight-pin input-only port, no drivers or direction control.
// R13: input port read returns current pin levels.
// R14: pin chosen as analog channel reads 0.
// R15: input port pins always high impedance.
// R16: subsleep holds five-pin port state like sleep.
module gpb_ports #(
	parameter bit FLASH_VARIANT = 1'b0
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// register port
	input wire gpb_pkg::gpb_req_s bus_req,
	output logic [7:0] bus_rdata,
	// operating mode and analog channel select
	input wire gpb_pkg::gpb_mode_e power_mode,
	input wire logic analog_enable,
	input wire logic [3:0] analog_channel_select,
	// five-pin port
	input wire logic [4:0] bidir_port_pin_in,
	output gpb_pkg::gpb_pin_s bidir_port_pin,
	// input-only port
	input wire logic [7:0] input_port_pin_in
);
	logic [4:0] data_ff;
	logic [4:0] dir_ff;
	logic [4:0] bsync1_ff, bsync2_ff;
	logic [7:0] isync1_ff, isync2_ff;
	logic [4:0] pin_out_ff;
	logic [4:0] pin_oe_n_ff;
	logic [7:0] rdata_ff;
	logic [4:0] nxt_pin_out, nxt_pin_oe_n;
	logic [4:0] bidir_read;
	logic [7:0] input_read;
	logic [7:0] nxt_rdata;
	logic [4:0] wr_mask;
	logic hold_mode, release_mode;

	// writable bits; flash variant drops bit 0
	assign wr_mask = FLASH_VARIANT ? 5'h1e : 5'h1f; // [R04]

	// pin synchronisers
	always_ff @(posedge core_clk) begin
		bsync1_ff <= bidir_port_pin_in;
		bsync2_ff <= bsync1_ff;
		isync1_ff <= input_port_pin_in;
		isync2_ff <= isync1_ff;
	end

	// data register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			data_ff <= gpb_pkg::BIDIR_DATA_RST[4:0]; // [R07]
		end else if (bus_req.wr && bus_req.addr == gpb_pkg::BIDIR_DATA_ADDR) begin
			data_ff <= bus_req.wdata[4:0] & wr_mask; // [R02] [R03] [R04]
		end
	end

	// direction register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			dir_ff <= gpb_pkg::BIDIR_DIR_RST[4:0]; // [R09]
		end else if (bus_req.wr && bus_req.addr == gpb_pkg::BIDIR_DIR_ADDR) begin
			dir_ff <= bus_req.wdata[4:0] & wr_mask; // [R04]
		end
	end

	// pin drive per mode
	assign hold_mode = (power_mode == gpb_pkg::GPB_MODE_SLEEP) ||
		(power_mode == gpb_pkg::GPB_MODE_SUBSLEEP) ||
		(power_mode == gpb_pkg::GPB_MODE_WATCH); // [R11] [R16]
	assign release_mode = (power_mode == gpb_pkg::GPB_MODE_STANDBY); // [R11]

	always_comb begin
		nxt_pin_out = pin_out_ff;
		nxt_pin_oe_n = pin_oe_n_ff;
		if (release_mode) begin
			nxt_pin_oe_n = 5'h1f; // [R11]
		end else if (!hold_mode) begin
			nxt_pin_out = data_ff; // [R08]
			nxt_pin_oe_n = ~(dir_ff & wr_mask); // [R08] [R01]
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pin_out_ff <= gpb_pkg::BIDIR_ZERO;
			pin_oe_n_ff <= 5'h1f; // [R11]
		end else begin
			pin_out_ff <= nxt_pin_out;
			pin_oe_n_ff <= nxt_pin_oe_n;
		end
	end

	assign bidir_port_pin.out = pin_out_ff;
	assign bidir_port_pin.oe_n = pin_oe_n_ff;

	// read mux
	always_comb begin
		bidir_read = ((dir_ff & data_ff) | (~dir_ff & bsync2_ff)) & wr_mask; // [R05] [R06]
		input_read = isync2_ff; // [R13] [R12] [R15]
		if (analog_enable && analog_channel_select < gpb_pkg::CHSEL_IN_LIMIT) begin
			input_read[analog_channel_select[2:0]] = 1'b0; // [R14]
		end
		nxt_rdata = gpb_pkg::UNMAPPED_VAL;
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				gpb_pkg::BIDIR_DATA_ADDR: begin
					nxt_rdata = {gpb_pkg::RSVD_HI_VAL, gpb_pkg::RSVD_B5_VAL,
						bidir_read}; // [R02] [R03]
				end
				gpb_pkg::INPUT_DATA_ADDR: begin
					nxt_rdata = input_read;
				end
				gpb_pkg::BIDIR_DIR_ADDR: begin
					nxt_rdata = gpb_pkg::DIR_READ_VAL; // [R10]
				end
				default: begin
					nxt_rdata = gpb_pkg::UNMAPPED_VAL;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rdata_ff <= gpb_pkg::UNMAPPED_VAL;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign bus_rdata = rdata_ff;

	// checks on read data
	a_dir_read_ones: assert property (@(posedge core_clk) disable iff (!rst_n) // [R10]
		bus_req.rd &&
		bus_req.addr == gpb_pkg::BIDIR_DIR_ADDR
		|=> bus_rdata == gpb_pkg::DIR_READ_VAL)
		else $error("direction read not all ones");

	a_data_rsvd_bits: assert property (@(posedge core_clk) disable iff (!rst_n) // [R02]
		bus_req.rd &&
		bus_req.addr == gpb_pkg::BIDIR_DATA_ADDR
		|=> bus_rdata[7:6] == gpb_pkg::RSVD_HI_VAL)
		else $error("reserved bits 7 and 6 not ones");

	a_bit5_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // [R03]
		bus_req.rd &&
		bus_req.addr == gpb_pkg::BIDIR_DATA_ADDR
		|=> bus_rdata[5] == gpb_pkg::RSVD_B5_VAL)
		else $error("bit 5 not zero");

	a_flash_bit0: assert property (@(posedge core_clk) disable iff (!rst_n) // [R04]
		FLASH_VARIANT && bus_req.rd &&
		bus_req.addr == gpb_pkg::BIDIR_DATA_ADDR
		|=> !bus_rdata[0])
		else $error("flash bit 0 not zero");

	a_out_readback: assert property (@(posedge core_clk) disable iff (!rst_n) // [R05]
		bus_req.rd &&
		bus_req.addr == gpb_pkg::BIDIR_DATA_ADDR
		|=> ((bus_rdata[4:0] ^ $past(data_ff)) & $past(dir_ff & wr_mask)) == 5'h00)
		else $error("output readback not latched data");

	a_in_readback: assert property (@(posedge core_clk) disable iff (!rst_n) // [R06]
		bus_req.rd &&
		bus_req.addr == gpb_pkg::BIDIR_DATA_ADDR
		|=> ((bus_rdata[4:0] ^ $past(bsync2_ff)) & $past(~dir_ff & wr_mask)) == 5'h00)
		else $error("input readback not pin level");

	a_input_level: assert property (@(posedge core_clk) disable iff (!rst_n) // [R13]
		bus_req.rd && !analog_enable &&
		bus_req.addr == gpb_pkg::INPUT_DATA_ADDR
		|=> bus_rdata == $past(isync2_ff))
		else $error("input port read wrong");

	a_analog_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // [R14]
		bus_req.rd && bus_req.addr == gpb_pkg::INPUT_DATA_ADDR &&
		analog_enable && analog_channel_select < gpb_pkg::CHSEL_IN_LIMIT
		|=> !bus_rdata[$past(analog_channel_select[2:0])])
		else $error("analog pin not zero");

	a_analog_others: assert property (@(posedge core_clk) disable iff (!rst_n) // [R14]
		bus_req.rd && bus_req.addr == gpb_pkg::INPUT_DATA_ADDR &&
		analog_enable && analog_channel_select < gpb_pkg::CHSEL_IN_LIMIT
		|=> ((bus_rdata ^ $past(isync2_ff)) & ~(8'h01 << $past(analog_channel_select[2:0]))) == 8'h00)
		else $error("non-analog pins of input port read wrong");

	a_analog_off_range: assert property (@(posedge core_clk) disable iff (!rst_n) // [R14]
		bus_req.rd && bus_req.addr == gpb_pkg::INPUT_DATA_ADDR &&
		analog_enable && analog_channel_select >= gpb_pkg::CHSEL_IN_LIMIT
		|=> bus_rdata == $past(isync2_ff))
		else $error("input port zeroed for channel outside port");

	a_rdata_idle: assert property (@(posedge core_clk) disable iff (!rst_n) // [R13]
		!bus_req.rd &&
		rst_n
		|=> bus_rdata == gpb_pkg::UNMAPPED_VAL)
		else $error("read data not cleared after read cycle");

	a_unmapped_read: assert property (@(posedge core_clk) disable iff (!rst_n) // [R13]
		bus_req.rd && bus_req.addr != gpb_pkg::BIDIR_DATA_ADDR &&
		bus_req.addr != gpb_pkg::INPUT_DATA_ADDR && bus_req.addr != gpb_pkg::BIDIR_DIR_ADDR
		|=> bus_rdata == gpb_pkg::UNMAPPED_VAL)
		else $error("unmapped read not zero");

	// checks on register state
	a_data_write: assert property (@(posedge core_clk) disable iff (!rst_n) // [R01]
		bus_req.wr &&
		bus_req.addr == gpb_pkg::BIDIR_DATA_ADDR
		|=> data_ff == ($past(bus_req.wdata[4:0]) & wr_mask))
		else $error("data register write lost");

	a_data_keep: assert property (@(posedge core_clk) disable iff (!rst_n) // [R01]
		!(bus_req.wr &&
		bus_req.addr == gpb_pkg::BIDIR_DATA_ADDR)
		|=> $stable(data_ff))
		else $error("data register changed without write");

	a_dir_write: assert property (@(posedge core_clk) disable iff (!rst_n) // [R08]
		bus_req.wr &&
		bus_req.addr == gpb_pkg::BIDIR_DIR_ADDR
		|=> dir_ff == ($past(bus_req.wdata[4:0]) & wr_mask))
		else $error("direction register write lost");

	a_dir_keep: assert property (@(posedge core_clk) disable iff (!rst_n) // [R08]
		!(bus_req.wr &&
		bus_req.addr == gpb_pkg::BIDIR_DIR_ADDR)
		|=> $stable(dir_ff))
		else $error("direction register changed without write");

	a_flash_no_store: assert property (@(posedge core_clk) disable iff (!rst_n) // [R04]
		FLASH_VARIANT &&
		rst_n
		|-> !data_ff[0] && !dir_ff[0])
		else $error("flash bit 0 stored");

	a_reset_values: assert property (@(posedge core_clk) // [R07]
		!rst_n
		|=> data_ff == gpb_pkg::BIDIR_DATA_RST[4:0] && bus_rdata == gpb_pkg::UNMAPPED_VAL)
		else $error("data reset value wrong");

	a_reset_dir: assert property (@(posedge core_clk) // [R09]
		!rst_n
		|=> dir_ff == gpb_pkg::BIDIR_DIR_RST[4:0])
		else $error("direction reset value wrong");

	// checks on pin drive
	a_reset_float: assert property (@(posedge core_clk) // [R11]
		!rst_n
		|=> pin_oe_n_ff == 5'h1f)
		else $error("pins driven in reset");

	a_standby_float: assert property (@(posedge core_clk) disable iff (!rst_n) // [R11]
		release_mode
		|=> bidir_port_pin.oe_n == 5'h1f)
		else $error("pins driven in standby");

	a_hold_state: assert property (@(posedge core_clk) disable iff (!rst_n) // [R16]
		hold_mode ##1
		hold_mode
		|-> $stable(pin_oe_n_ff) && $stable(pin_out_ff))
		else $error("pins changed in hold mode");

	a_drive_active: assert property (@(posedge core_clk) disable iff (!rst_n) // [R08]
		power_mode == gpb_pkg::GPB_MODE_ACTIVE
		|=> pin_oe_n_ff == ~($past(dir_ff) & wr_mask))
		else $error("direction not applied");

	a_drive_subactive: assert property (@(posedge core_clk) disable iff (!rst_n) // [R11]
		power_mode == gpb_pkg::GPB_MODE_SUBACTIVE
		|=> pin_oe_n_ff == ~($past(dir_ff) & wr_mask))
		else $error("direction not applied in subactive");

	a_drive_value: assert property (@(posedge core_clk) disable iff (!rst_n) // [R08]
		!hold_mode &&
		!release_mode
		|=> pin_out_ff == $past(data_ff))
		else $error("pin drive not data register");

	a_flash_pin0: assert property (@(posedge core_clk) disable iff (!rst_n) // [R04]
		FLASH_VARIANT &&
		rst_n
		|-> pin_oe_n_ff[0])
		else $error("flash bit 0 pin driven");

	// checks on pin synchronisers
	a_bidir_sync: assert property (@(posedge core_clk) disable iff (!rst_n) // [R06]
		rst_n &&
		$past(rst_n, 2)
		|-> bsync2_ff == $past(bidir_port_pin_in, 2))
		else $error("five-pin synchroniser wrong");

	a_input_sync: assert property (@(posedge core_clk) disable iff (!rst_n) // [R13]
		rst_n &&
		$past(rst_n, 2)
		|-> isync2_ff == $past(input_port_pin_in, 2))
		else $error("input port synchroniser wrong");
endmodule

/* test/gpb_pin_model.sv */
`timescale 1ns/10ps
module gpb_pin_model (
	// design drive and outside source
	input wire gpb_pkg::gpb_pin_s pin,
	input wire logic [4:0] ext,
	// resolved wire level
	output logic [4:0] lvl
);
	// an enabled driver wins, else the outside source sets the wire
	assign lvl = (pin.out & ~pin.oe_n) | (ext & pin.oe_n);
endmodule

/* test/gpb_ports_bench.sv */
`timescale 1ns/10ps
module gpb_ports_bench;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	gpb_pkg::gpb_req_s req = '0;
	gpb_pkg::gpb_mode_e mode = gpb_pkg::GPB_MODE_ACTIVE;
	gpb_pkg::gpb_pin_s pin;
	gpb_pkg::gpb_pin_s pin_f;
	logic [7:0] rdata;
	logic [7:0] rdata_f;
	logic [7:0] inp = 8'h00;
	logic [7:0] d;
	logic [4:0] ext = 5'h00;
	logic [4:0] lvl;
	logic [4:0] dir = 5'h00;
	logic [4:0] dat = 5'h00;
	logic [3:0] ch = 4'h0;
	logic aen = 1'b0;
	int n_fail = 0;
	int n_tests = 0;
	int cyc = 0;
	int seed = 91582;
	always #20 core_clk = ~core_clk;
	gpb_ports i_gpb_ports (.core_clk(core_clk), .rst_n(rst_n), .bus_req(req), .bus_rdata(rdata),
		.power_mode(mode), .analog_enable(aen), .analog_channel_select(ch),
		.bidir_port_pin_in(lvl), .bidir_port_pin(pin), .input_port_pin_in(inp));
	gpb_ports #(.FLASH_VARIANT(1'b1)) i_gpb_ports_flash (.core_clk(core_clk), .rst_n(rst_n),
		.bus_req(req), .bus_rdata(rdata_f), .power_mode(mode), .analog_enable(aen),
		.analog_channel_select(ch), .bidir_port_pin_in(lvl), .bidir_port_pin(pin_f),
		.input_port_pin_in(inp));
	gpb_pin_model i_gpb_pin_model (.pin(pin), .ext(ext), .lvl(lvl));
	task wrap_up;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task chk_pins(input logic [4:0] oe_n, input logic [4:0] out);
		chk({3'h0, pin.oe_n}, {3'h0, oe_n});
		chk({3'h0, pin.out & ~oe_n}, {3'h0, out & ~oe_n});
		chk({7'h00, pin_f.oe_n[0]}, 8'h01);
	endtask
	// write strobe stays up until the next request or idle
	task wr(input logic [15:0] a, input logic [7:0] v);
		req <= '{a, v, 1'b1, 1'b0};
		@(posedge core_clk);
	endtask
	task idle;
		req <= '0;
		@(posedge core_clk);
	endtask
	task rd(input logic [15:0] a, input logic [7:0] exp);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge core_clk);
		req <= '0;
		@(negedge core_clk);
		chk(rdata, exp);
		chk(rdata_f, (a == gpb_pkg::BIDIR_DATA_ADDR) ? (exp & 8'hfe) : exp);
		@(posedge core_clk);
	endtask
	function logic [7:0] exp_p9();
		return {3'b110, (dat & dir) | (ext & ~dir)};
	endfunction
	function logic [7:0] exp_in();
		return inp & ~((aen && ch < 4'h8) ? 8'h01 << ch : 8'h00);
	endfunction
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			wrap_up;
		end
	end
	initial begin
		repeat (16) @(posedge core_clk);
		chk_pins(5'h1f, 5'h00);
		rst_n <= 1'b1;
		@(posedge core_clk);
		rd(gpb_pkg::BIDIR_DATA_ADDR, exp_p9());
		rd(16'hffde, 8'h00);
		for (int k = 0; k < 24; k++) begin
			dir = $random(seed);
			d = $random(seed);
			dat = d[4:0];
			wr(gpb_pkg::BIDIR_DIR_ADDR, {3'h7, dir});
			wr(gpb_pkg::BIDIR_DATA_ADDR, d);
			wr(gpb_pkg::INPUT_DATA_ADDR, ~d);
			idle;
			ext <= $random(seed);
			inp <= $random(seed);
			aen <= $random(seed);
			ch <= $random(seed);
			repeat (4) @(posedge core_clk);
			chk_pins(~dir, dat);
			rd(gpb_pkg::BIDIR_DATA_ADDR, exp_p9());
			rd(gpb_pkg::INPUT_DATA_ADDR, exp_in());
			rd(gpb_pkg::BIDIR_DIR_ADDR, 8'hff);
		end
		dir = 5'h1f;
		wr(gpb_pkg::BIDIR_DIR_ADDR, 8'h1f);
		idle;
		mode <= gpb_pkg::GPB_MODE_SLEEP;
		wr(gpb_pkg::BIDIR_DATA_ADDR, {3'h0, ~dat});
		idle;
		repeat (3) @(posedge core_clk);
		chk_pins(5'h00, dat);
		mode <= gpb_pkg::GPB_MODE_STANDBY;
		repeat (3) @(posedge core_clk);
		chk_pins(5'h1f, 5'h00);
		mode <= gpb_pkg::GPB_MODE_SUBACTIVE;
		dat = ~dat;
		repeat (3) @(posedge core_clk);
		chk_pins(5'h00, dat);
		for (int m = 0; m < 2; m++) begin
			mode <= m ? gpb_pkg::GPB_MODE_WATCH : gpb_pkg::GPB_MODE_SUBSLEEP;
			wr(gpb_pkg::BIDIR_DATA_ADDR, {3'h0, ~dat});
			idle;
			repeat (3) @(posedge core_clk);
			chk_pins(5'h00, dat);
		end
		mode <= gpb_pkg::GPB_MODE_ACTIVE;
		dat = ~dat;
		repeat (3) @(posedge core_clk);
		chk_pins(5'h00, dat);
		rd(gpb_pkg::BIDIR_DATA_ADDR, exp_p9());
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk_pins(5'h1f, 5'h00);
		rst_n <= 1'b1;
		dat = 5'h00;
		dir = 5'h00;
		@(posedge core_clk);
		rd(gpb_pkg::BIDIR_DATA_ADDR, exp_p9());
		rd(gpb_pkg::BIDIR_DIR_ADDR, 8'hff);
		wrap_up;
	end
endmodule
